// *** logic/qp_map.svh ***
// Register indices, widths and reset values of the quad parallel port block.
// Assumes a 32-bit word-addressed register bus: byte address = 4 * index.
`ifndef QP_MAP_SVH
`define QP_MAP_SVH

// ****************************************
// Register indices (byte address is 4x)
// ****************************************
`define QP_IDX_P0_LATCH   6'h00
`define QP_IDX_P1_LATCH   6'h01
`define QP_IDX_P2_LATCH   6'h02
`define QP_IDX_P3_LATCH   6'h03
`define QP_IDX_P0_DRIVE   6'h0A
`define QP_IDX_P1_DRIVE   6'h0B
`define QP_IDX_T3_INVERT  6'h29
`define QP_IDX_P3_DRIVE   6'h2A
`define QP_IDX_P2_DRIVE   6'h2D
`define QP_IDX_P0_PIN     6'h30
`define QP_IDX_P1_PIN     6'h31
`define QP_IDX_P2_PIN     6'h32
`define QP_IDX_P3_PIN     6'h33

// ****************************************
// Port widths and implemented bit masks
// ****************************************
`define QP_P0_W           8
`define QP_P1_W           6
`define QP_P2_W           4
`define QP_P3_W           8
`define QP_P0_MASK        8'hFF
`define QP_P1_MASK        8'h3F
`define QP_P2_MASK        8'h0F
`define QP_P3_MASK        8'hFF
`define QP_T3_MASK        8'h01

// ****************************************
// Reset values and crystal pin bits
// ****************************************
`define QP_LATCH_RST      8'hFF
`define QP_DRIVE_RST      8'h00
`define QP_T3_RST         1'b0
`define QP_XTAL_BITS      8'h06

`endif

// *** logic/qp_pkg.sv ***
// Types shared by the quad parallel port block.
// Assumes qp_map.svh supplies the numeric constants.
package qp_pkg;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef logic [7:0] qp_byte_t;

    // Secondary-function output request of one port, one bit per pin
    typedef struct packed {
        qp_byte_t en;
        qp_byte_t val;
    } qp_alt_t;

    // Pad drive of one port
    typedef struct packed {
        qp_byte_t dout;
        qp_byte_t oe;
    } qp_pad_t;

endpackage

// *** logic/qp_ports.sv ***
// Four parallel I/O ports with output latches, drive-type select and live pin reads.
// Assumes classic Wishbone on mclk, pads resolved outside from dout/oe, pins asynchronous.
//
// Overview of operation
// - Port widths are eight, six, four and eight bits for ports zero to three.
// - Outputs keep a latch per bit; pin reads return live levels, no capture.
// - Pin levels are sampled in the first state of the read access.
// - Pin outputs change one edge after the write access, when the pads register the new latch.
// - Drive-select bit 0 gives open drain, 1 gives push-pull.
// - Reset sets every latch bit to 1 and every drive-select bit to 0.
// - Latch and pin-read registers sit at separate addresses per port.
// - Port one upper two bits read as undefined (here zero).
// - Port two upper four bits read as undefined (here zero).
// - One-bit register optionally inverts the timer-three input.
// - Port-two bits one and two get a pull-up when push-pull selected.
// - Dual-clock mode hands port-two bits one and two to slow crystal.
// - Falling edge on port-two bit zero sets interrupt even when driven.
// - All port registers sit in the lowest 64 register addresses.
`include "qp_map.svh"

module qp_ports
    import qp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic [7:0]  port_zero_pin_in,
    input  wire logic [5:0]  port_one_pin_in,
    input  wire logic [3:0]  port_two_pin_in,
    input  wire logic [7:0]  port_three_pin_in,
    input  wire qp_alt_t     port_zero_alt,
    input  wire qp_alt_t     port_one_alt,
    input  wire qp_alt_t     port_two_alt,
    input  wire qp_alt_t     port_three_alt,
    output qp_pad_t          port_zero_pad,
    output qp_pad_t          port_one_pad,
    output qp_pad_t          port_two_pad,
    output qp_pad_t          port_three_pad,
    input  wire logic        dual_clock_mode,
    output logic             slow_crystal_en,
    output logic      [1:0]  port_two_pullup_en,
    output logic             port_two_bit_zero_fall,
    input  wire logic        timer_three_src,
    output logic             timer_three_in,
    output logic             timer_three_input_invert
);

    // ****************************************
    // Constant tables
    // ****************************************
    localparam logic [5:0] LATCH_IDX [4] = '{`QP_IDX_P0_LATCH, `QP_IDX_P1_LATCH,
                                              `QP_IDX_P2_LATCH, `QP_IDX_P3_LATCH};
    localparam logic [5:0] DRIVE_IDX [4] = '{`QP_IDX_P0_DRIVE, `QP_IDX_P1_DRIVE,
                                              `QP_IDX_P2_DRIVE, `QP_IDX_P3_DRIVE};
    localparam logic [5:0] PIN_IDX   [4] = '{`QP_IDX_P0_PIN, `QP_IDX_P1_PIN,
                                              `QP_IDX_P2_PIN, `QP_IDX_P3_PIN};
    localparam qp_byte_t   PORT_MASK [4] = '{`QP_P0_MASK, `QP_P1_MASK,
                                              `QP_P2_MASK, `QP_P3_MASK};

    // ****************************************
    // Bus decode
    // ****************************************
    logic       ack_q;
    wire  [5:0] adr_idx   = adr_i[7:2];
    wire        req       = cyc_i & stb_i;
    wire        in_space  = (adr_i[1:0] == 2'b00);
    wire        wr_fire   = req & we_i & ack_q & sel_i[0] & in_space;
    wire        rd_take   = req & ~ack_q;
    wire        hit_t3    = in_space & (adr_idx == `QP_IDX_T3_INVERT);

    qp_byte_t   latch     [4];
    qp_byte_t   drive     [4];
    qp_byte_t   sync_a    [4];
    qp_byte_t   sync_b    [4];
    qp_alt_t    alt       [4];
    qp_pad_t    pad_q     [4];
    qp_byte_t   raw_pin   [4];
    qp_byte_t   rd_chain  [5];
    logic       t3_inv;
    logic       t3_sync_a;
    logic       t3_sync_b;
    logic       bit_zero_prev;

    assign ack_o                    = ack_q;
    assign raw_pin[0]               = port_zero_pin_in;
    assign raw_pin[1]               = {2'b00, port_one_pin_in};
    assign raw_pin[2]               = {4'h0, port_two_pin_in};
    assign raw_pin[3]               = port_three_pin_in;
    assign alt[0]                   = port_zero_alt;
    assign alt[1]                   = port_one_alt;
    assign alt[2]                   = port_two_alt;
    assign alt[3]                   = port_three_alt;
    assign port_zero_pad            = pad_q[0];
    assign port_one_pad             = pad_q[1];
    assign port_two_pad             = pad_q[2];
    assign port_three_pad           = pad_q[3];
    assign rd_chain[0]              = hit_t3 ? {7'h00, t3_inv} : 8'h00;
    assign timer_three_input_invert = t3_inv;

    // ****************************************
    // Per-port latches, drive select, pads
    // ****************************************
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_port
            wire      hit_lat = in_space & (adr_idx == LATCH_IDX[p]);
            wire      hit_drv = in_space & (adr_idx == DRIVE_IDX[p]);
            wire      hit_pin = in_space & (adr_idx == PIN_IDX[p]);
            // Latch gated by an active secondary output
            wire qp_byte_t eff = latch[p] & ~(alt[p].en & ~alt[p].val);
            // Port two bits one and two leave the pad to the crystal
            wire qp_byte_t xtal = (p == 2 && dual_clock_mode) ? `QP_XTAL_BITS : 8'h00;
            wire qp_byte_t next_dout = drive[p] & eff & ~xtal & PORT_MASK[p];
            wire qp_byte_t next_oe   = (drive[p] | ~eff) & ~xtal & PORT_MASK[p];
            // Unimplemented upper bits read as zero
            wire qp_byte_t rd_val = (hit_lat ? latch[p] : 8'h00)
                                  | (hit_drv ? drive[p] : 8'h00)
                                  | (hit_pin ? sync_b[p] : 8'h00);

            assign rd_chain[p+1] = rd_chain[p] | (rd_val & PORT_MASK[p]);

            // Output latch and drive select
            always_ff @(posedge mclk) begin
                if (srst) begin
                    latch[p] <= `QP_LATCH_RST;
                    drive[p] <= `QP_DRIVE_RST;
                end else if (wr_fire && hit_lat) begin
                    latch[p] <= dat_i[7:0] | ~PORT_MASK[p];
                end else if (wr_fire && hit_drv) begin
                    drive[p] <= dat_i[7:0] & PORT_MASK[p];
                end
            end

            // Pin synchroniser, no capture beyond it
            always_ff @(posedge mclk) begin
                sync_a[p] <= raw_pin[p];
                sync_b[p] <= sync_a[p];
            end

            // Registered pad drive, one edge after the latch
            always_ff @(posedge mclk) begin
                if (srst) begin
                    pad_q[p] <= '{dout: 8'h00, oe: 8'h00};
                end else begin
                    pad_q[p] <= '{dout: next_dout, oe: next_oe};
                end
            end
        end
    endgenerate

    // ****************************************
    // Bus answer
    // ****************************************
    // One wait state; read data is sampled when the request is first seen
    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_q <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= rd_take;
            if (rd_take) begin
                dat_o <= {24'h00_0000, we_i ? 8'h00 : rd_chain[4]};
            end
        end
    end

    // ****************************************
    // Timer-three input select
    // ****************************************
    // Invert register
    always_ff @(posedge mclk) begin
        if (srst) begin
            t3_inv <= `QP_T3_RST;
        end else if (wr_fire && hit_t3) begin
            t3_inv <= dat_i[0];
        end
    end

    // Timer source is sampled then phase-selected
    always_ff @(posedge mclk) begin
        t3_sync_a <= timer_three_src;
        t3_sync_b <= t3_sync_a;
        if (srst) begin
            timer_three_in <= 1'b0;
        end else begin
            timer_three_in <= t3_sync_b ^ t3_inv;
        end
    end

    // ****************************************
    // Port two special pins
    // ****************************************
    // Crystal enable, pull-ups, and falling edge on bit zero
    // Edge history starts high, the pulled-up idle level, so reset gives no false edge
    always_ff @(posedge mclk) begin
        if (srst) begin
            slow_crystal_en        <= 1'b0;
            port_two_pullup_en     <= 2'b00;
            port_two_bit_zero_fall <= 1'b0;
            bit_zero_prev          <= 1'b1;
        end else begin
            slow_crystal_en        <= dual_clock_mode;
            port_two_pullup_en     <= drive[2][2:1] & {2{~dual_clock_mode}};
            bit_zero_prev          <= sync_b[2][0];
            port_two_bit_zero_fall <= bit_zero_prev & ~sync_b[2][0];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Port zero and port three latches and drive selects hold their reset values when reset lifts
    AST_RESET_LATCH: assert property (@(posedge mclk)
        $fell(srst) |-> latch[0] == `QP_LATCH_RST && latch[3] == `QP_LATCH_RST
                        && drive[0] == `QP_DRIVE_RST && drive[3] == `QP_DRIVE_RST)
        else $error("Latch or drive select not at reset value");

    // Port one and port three pads come out of reset released, never driving
    AST_PIN_RESET_OD: assert property (@(posedge mclk) disable iff (srst)
        $past(srst) |-> pad_q[1].dout == 8'h00 && pad_q[1].oe == 8'h00
                        && pad_q[3].dout == 8'h00 && pad_q[3].oe == 8'h00)
        else $error("Pad not released after reset");

    // ****************************************
    // Bus handshake checks
    // ****************************************
    // A request seen is answered after exactly one wait state
    AST_ACK_AFTER_REQ: assert property (@(posedge mclk) disable iff (srst)
        rd_take |=> ack_q)
        else $error("Request not acknowledged after one wait state");

    // Acknowledge stands one cycle, so a write lands only once
    AST_ACK_ONE_CYCLE: assert property (@(posedge mclk) disable iff (srst)
        ack_q |=> !ack_q)
        else $error("Acknowledge held longer than one cycle");

    // Pin read returns the synchronised level of the request edge
    AST_PIN_READ: assert property (@(posedge mclk) disable iff (srst)
        rd_take && !we_i && in_space && adr_idx == `QP_IDX_P1_PIN
        |=> dat_o == {26'h000_0000, $past(sync_b[1][5:0])})
        else $error("Pin read did not return live level");

    // Port two reads carry zero above bit three
    AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (srst)
        ack_q |-> dat_o[7:4] == 4'h0
                  || !($past(adr_idx) inside {`QP_IDX_P2_LATCH, `QP_IDX_P2_DRIVE, `QP_IDX_P2_PIN}))
        else $error("Port two upper bits not zero");

    // Port one reads carry zero above bit five
    AST_P1_UPPER_ZERO: assert property (@(posedge mclk) disable iff (srst)
        ack_q |-> dat_o[7:6] == 2'b00
                  || !($past(adr_idx) inside {`QP_IDX_P1_LATCH, `QP_IDX_P1_DRIVE, `QP_IDX_P1_PIN}))
        else $error("Port one upper bits not zero");

    // ****************************************
    // Port drive checks
    // ****************************************
    // A write on the acknowledge edge lands in the latch
    AST_WRITE_LATCH: assert property (@(posedge mclk) disable iff (srst)
        wr_fire && adr_idx == `QP_IDX_P0_LATCH |=> latch[0] == $past(dat_i[7:0]))
        else $error("Port zero latch did not take written value");

    // A write on the acknowledge edge lands in the drive select
    AST_DRIVE_WRITE: assert property (@(posedge mclk) disable iff (srst)
        wr_fire && adr_idx == `QP_IDX_P0_DRIVE |=> drive[0] == $past(dat_i[7:0]))
        else $error("Port zero drive select did not take written value");

    // Push-pull pad shows the new latch one edge after the write
    AST_PAD_FOLLOWS: assert property (@(posedge mclk) disable iff (srst)
        wr_fire && adr_idx == `QP_IDX_P0_LATCH && drive[0] == 8'hFF && alt[0].en == 8'h00
        ##1 alt[0].en == 8'h00 && drive[0] == 8'hFF
        |=> pad_q[0].dout == $past(latch[0]))
        else $error("Push-pull pad did not follow latch");

    // Open drain on port three only sinks where the latch is zero
    AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (srst)
        drive[3] == 8'h00 && alt[3].en == 8'h00
        |=> pad_q[3].dout == 8'h00 && pad_q[3].oe == ~$past(latch[3]))
        else $error("Open drain drive wrong");

    // Open drain on port zero, where the latch does change
    AST_OPEN_DRAIN_P0: assert property (@(posedge mclk) disable iff (srst)
        drive[0] == 8'h00 && alt[0].en == 8'h00
        |=> pad_q[0].dout == 8'h00 && pad_q[0].oe == ~$past(latch[0]))
        else $error("Port zero open drain drive wrong");

    // A low secondary output pulls a push-pull pin low
    AST_ALT_AND: assert property (@(posedge mclk) disable iff (srst)
        alt[0].en[1] && !alt[0].val[1] && drive[0][1]
        |=> pad_q[0].dout[1] == 1'b0 && pad_q[0].oe[1])
        else $error("Secondary output not ANDed with latch");

    // Bits above a port's width never drive
    AST_PAD_WIDTH: assert property (@(posedge mclk) disable iff (srst)
        pad_q[1].oe[7:6] == 2'b00 && pad_q[1].dout[7:6] == 2'b00
        && pad_q[2].oe[7:4] == 4'h0 && pad_q[2].dout[7:4] == 4'h0)
        else $error("Pad driven above port width");

    // ****************************************
    // Special pin checks
    // ****************************************
    // Crystal pins released and pull-ups off in dual-clock mode
    AST_XTAL_RELEASE: assert property (@(posedge mclk) disable iff (srst)
        dual_clock_mode ##1 dual_clock_mode
        |-> pad_q[2].oe[2:1] == 2'b00 && port_two_pullup_en == 2'b00)
        else $error("Crystal pins still driven in dual-clock mode");

    // Crystal enable follows the mode one edge later
    AST_CRYSTAL_EN: assert property (@(posedge mclk) disable iff (srst)
        !$past(srst) |-> slow_crystal_en == $past(dual_clock_mode))
        else $error("Crystal enable does not follow the mode");

    // Pull-ups follow the push-pull select of bits one and two
    AST_PULLUP: assert property (@(posedge mclk) disable iff (srst)
        !dual_clock_mode |=> port_two_pullup_en == $past(drive[2][2:1]))
        else $error("Pull-up enable does not follow push-pull select");

    // One pulse for each falling edge of bit zero
    AST_FALL_EDGE: assert property (@(posedge mclk) disable iff (srst)
        $fell(sync_b[2][0]) |=> port_two_bit_zero_fall ##1 !port_two_bit_zero_fall)
        else $error("Bit zero falling edge not reported once");

    // Timer input inverted while the select is set
    AST_T3_PHASE: assert property (@(posedge mclk) disable iff (srst)
        t3_inv && $past(t3_inv) |-> timer_three_in == !$past(t3_sync_b))
        else $error("Timer three input not inverted");

    // Timer input passed straight while the select is clear
    AST_T3_PLAIN: assert property (@(posedge mclk) disable iff (srst)
        !$past(srst) && !t3_inv && !$past(t3_inv) |-> timer_three_in == $past(t3_sync_b))
        else $error("Timer three input inverted without select");

endmodule

// *** sim/qp_pin_model.sv ***
// Board-side model of the eight lines of one port.
// Assumes pad drive from the block and a board pull-up on every line.
module qp_pin_model
    import qp_pkg::*;
(
    input  wire qp_pad_t  pad,
    input  wire qp_byte_t ext_en,
    input  wire qp_byte_t ext_val,
    output qp_byte_t      pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Driven pad wins, then a held outside source, else the pull-up lifts the line
    assign pin = (pad.oe & pad.dout) | (~pad.oe & ~ext_en) | (~pad.oe & ext_en & ext_val);
endmodule

// *** sim/test_quad_parallel_io_ports.sv ***
// Self-checking bench for the quad parallel port block.
// Assumes qp_ports on classic Wishbone and one qp_pin_model per port.
`include "qp_map.svh"
module test_quad_parallel_io_ports
    import qp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Signals
    // ****************************************
    logic        mclk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
    logic        dual = 0, t3src = 0, ack, slow_en, t3in, t3inv, fall;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0;
    logic [31:0] dat = 0, rdat, q;
    logic [1:0]  pu;
    qp_alt_t     alt0 = '0;
    qp_pad_t     pad [4];
    qp_byte_t    pin [4];
    qp_byte_t    ext_en [4] = '{default: 8'h00};
    qp_byte_t    ext_val [4] = '{default: 8'h00};
    int          errors = 0, comparisons = 0, cycles = 0;

    always #2.5 mclk = ~mclk;

    qp_ports i_qp_ports (.mclk(mclk), .srst(srst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
        .port_zero_pin_in(pin[0]), .port_one_pin_in(pin[1][5:0]),
        .port_two_pin_in(pin[2][3:0]), .port_three_pin_in(pin[3]),
        .port_zero_alt(alt0), .port_one_alt('0), .port_two_alt('0), .port_three_alt('0),
        .port_zero_pad(pad[0]), .port_one_pad(pad[1]), .port_two_pad(pad[2]),
        .port_three_pad(pad[3]), .dual_clock_mode(dual), .slow_crystal_en(slow_en),
        .port_two_pullup_en(pu), .port_two_bit_zero_fall(fall), .timer_three_src(t3src),
        .timer_three_in(t3in), .timer_three_input_invert(t3inv));

    for (genvar k = 0; k < 4; k++) begin : g_pin
        qp_pin_model i_qp_pin_model (.pad(pad[k]), .ext_en(ext_en[k]), .ext_val(ext_val[k]), .pin(pin[k]));
    end

    // Cycle ceiling
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles > 4000) begin
            errors++;
            report_and_stop;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic report_and_stop;
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; holds until ack is sampled, then releases
    task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d, output logic [31:0] r);
        @(posedge mclk);
        cyc <= 1;
        stb <= 1;
        we  <= w;
        sel <= 4'h1;
        adr <= {ix, 2'b00};
        dat <= {24'h00_0000, d};
        // The cycle ceiling ends a wait that never sees ack
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 0;
        stb <= 0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [5:0] ix [9] = '{`QP_IDX_P0_LATCH, `QP_IDX_P1_LATCH, `QP_IDX_P2_LATCH, `QP_IDX_P3_LATCH,
            `QP_IDX_P0_DRIVE, `QP_IDX_P1_DRIVE, `QP_IDX_P2_DRIVE, `QP_IDX_P3_DRIVE, `QP_IDX_T3_INVERT};
        logic [7:0] ex [9] = '{8'hFF, 8'h3F, 8'h0F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 9; k++) begin
            wb(0, ix[k], 8'h00, q);
            chk("reset value", q, {24'h00_0000, ex[k]});
        end
        for (int k = 0; k < 4; k++) begin
            chk("reset pad oe", 32'(pad[k].oe), 32'h0000_0000);
            chk("reset pad dout", 32'(pad[k].dout), 32'h0000_0000);
        end
    endtask

    task automatic t_drive;
        wb(1, `QP_IDX_P0_LATCH, 8'h5A, q);
        #1 chk("pad before", 32'(pad[0].oe), 32'h0000_0000);
        @(posedge mclk);
        #1 chk("od oe", 32'(pad[0].oe), 32'h0000_00A5);
        chk("od dout", 32'(pad[0].dout), 32'h0000_0000);
        wb(1, `QP_IDX_P0_DRIVE, 8'hFF, q);
        @(posedge mclk);
        #1 chk("pp dout", 32'(pad[0].dout), 32'h0000_005A);
        @(posedge mclk);
        alt0 <= '{en: 8'h02, val: 8'h00};
        repeat (2) @(posedge mclk);
        #1 chk("alt dout", 32'(pad[0].dout), 32'h0000_0058);
        @(posedge mclk);
        alt0 <= '0;
        wb(1, `QP_IDX_P0_LATCH, 8'h3C, q);
        @(posedge mclk);
        #1 chk("pp follow", 32'(pad[0].dout), 32'h0000_003C);
        wb(0, `QP_IDX_P0_LATCH, 8'h00, q);
        chk("latch read", q, 32'h0000_003C);
        wb(0, `QP_IDX_P0_DRIVE, 8'h00, q);
        chk("drive read", q, 32'h0000_00FF);
    endtask

    task automatic t_pins;
        @(posedge mclk);
        ext_en[3]  <= 8'hFF;
        ext_val[3] <= 8'hC3;
        ext_en[1]  <= 8'hFF;
        ext_val[1] <= 8'hE5;
        repeat (4) @(posedge mclk);
        wb(0, `QP_IDX_P3_PIN, 8'h00, q);
        chk("p3 pins", q, 32'h0000_00C3);
        wb(0, `QP_IDX_P3_LATCH, 8'h00, q);
        chk("p3 latch", q, 32'h0000_00FF);
        wb(0, `QP_IDX_P1_PIN, 8'h00, q);
        chk("p1 pins", q, 32'h0000_0025);
        wb(0, `QP_IDX_P0_PIN, 8'h00, q);
        chk("p0 pins", q, 32'h0000_003C);
        ext_en[3] <= 8'h00;
        ext_en[1] <= 8'h00;
    endtask

    task automatic t_port_two;
        int n;
        wb(1, `QP_IDX_P2_DRIVE, 8'h06, q);
        @(posedge mclk);
        #1 chk("pullups", 32'(pu), 32'h0000_0003);
        chk("p2 oe", 32'(pad[2].oe), 32'h0000_0006);
        @(posedge mclk);
        dual <= 1;
        repeat (3) @(posedge mclk);
        #1 chk("crystal en", 32'(slow_en), 32'h0000_0001);
        chk("crystal pins", 32'(pad[2].oe & 8'h06), 32'h0000_0000);
        chk("crystal pullups", 32'(pu), 32'h0000_0000);
        @(posedge mclk);
        dual <= 0;
        n = 0;
        wb(1, `QP_IDX_P2_LATCH, 8'hFE, q);
        // Count pulses while each one stands
        repeat (8) begin
            @(posedge mclk);
            #1;
            if (fall === 1'b1)
                n++;
        end
        chk("fall pulses", 32'(n), 32'h0000_0001);
        wb(0, `QP_IDX_P2_LATCH, 8'h00, q);
        chk("p2 latch", q, 32'h0000_000E);
        wb(1, `QP_IDX_P2_LATCH, 8'h0F, q);
        chk("crystal off", 32'(slow_en), 32'h0000_0000);
    endtask

    task automatic t_timer;
        @(posedge mclk);
        t3src <= 1;
        repeat (5) @(posedge mclk);
        #1 chk("timer plain", 32'(t3in), 32'h0000_0001);
        wb(1, `QP_IDX_T3_INVERT, 8'h01, q);
        repeat (3) @(posedge mclk);
        #1 chk("timer invert", 32'(t3in), 32'h0000_0000);
        chk("invert bit", 32'(t3inv), 32'h0000_0001);
        wb(0, 6'h07, 8'h00, q);
        chk("unmapped", q, 32'h0000_0000);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        srst <= 0;
        t_reset;
        t_drive;
        t_pins;
        t_port_two;
        t_timer;
        report_and_stop;
    end
endmodule
